// *** bench/mcc_monitor.sv ***
// Purpose: Port-level checks of the bus answer, the clock outputs and flash access.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Bound into mcc_top at the foot of this file.
`timescale 1ns/10ps
module mcc_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cpu_clk_o,
  input wire logic sys_clk_o,
  input wire logic acc_req_i,
  input wire logic acc_seq_i,
  input wire logic acc_busy_o,
  input wire logic acc_done_o,
  input wire logic [15:0] acc_rdata_o,
  input wire logic [15:0] flash_rdata_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_take;
    acc_req_i && !acc_busy_o;
  endsequence
  sequence s_seq_take;
    s_take ##0 acc_seq_i;
  endsequence
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("Bus request not answered in the next cycle.");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Bus answer stood longer than one cycle.");
  a_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("Bus answer without a request.");
  a_sys_cpu: assert property (sys_clk_o == cpu_clk_o)
    else $error("System clock differs from CPU clock.");
  a_take_bound: assert property (s_take |-> ##[2:5] acc_done_o)
    else $error("Flash access did not complete in time.");
  a_seq_fast: assert property (s_seq_take |-> ##2 acc_done_o)
    else $error("Sequential access took waitstates.");
  a_done_pulse: assert property (acc_done_o |=> !acc_done_o)
    else $error("Access done stood longer than one cycle.");
  a_rdata_capture: assert property (acc_done_o |-> acc_rdata_o == $past(flash_rdata_i))
    else $error("Access data not captured at completion.");
  a_rdata_hold: assert property (!acc_done_o |-> $stable(acc_rdata_o))
    else $error("Access data changed between accesses.");
endmodule

bind mcc_top mcc_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cpu_clk_o(cpu_clk_o), .sys_clk_o(sys_clk_o),
  .acc_req_i(acc_req_i), .acc_seq_i(acc_seq_i), .acc_busy_o(acc_busy_o),
  .acc_done_o(acc_done_o), .acc_rdata_o(acc_rdata_o), .flash_rdata_i(flash_rdata_i));

// *** bench/tb_master_clock_and_flash_wait_control.sv ***
// Purpose: Self-checking bench for master clock generation and flash waitstates.
// Assumes: Oscillator runs at an eighth and the VCO at a quarter of clk_i.
// Notes: Clock periods are counted in clk_i cycles between rising edges.
`timescale 1ns/10ps
module tb_master_clock_and_flash_wait_control;
  import mcc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, pll_ref_o, pll_enable_o, master_clk_o, cpu_clk_o, sys_clk_o;
  logic [4:0] feedback_multiply_factor_o;
  logic [1:0] vco_band_select_o;
  logic acc_req_i = 1'b0, acc_seq_i = 1'b0, acc_busy_o, acc_done_o;
  logic [15:0] flash_rdata_i = 16'h0;
  logic [15:0] acc_rdata_o;
  logic [2:0] ph = 3'h0;
  int num_errors = 0;
  int total_checks = 0;

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) ph <= ph + 3'h1;

  mcc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .oscillator_input_i(ph[2]),
    .vco_clk_i(ph[1]), .pll_ref_o(pll_ref_o), .pll_enable_o(pll_enable_o),
    .feedback_multiply_factor_o(feedback_multiply_factor_o),
    .vco_band_select_o(vco_band_select_o), .master_clk_o(master_clk_o),
    .cpu_clk_o(cpu_clk_o), .sys_clk_o(sys_clk_o), .acc_req_i(acc_req_i),
    .acc_seq_i(acc_seq_i), .flash_rdata_i(flash_rdata_i), .acc_busy_o(acc_busy_o),
    .acc_done_o(acc_done_o), .acc_rdata_o(acc_rdata_o));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("Checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1)
    begin
      check("bus_wait", 32'h0, 32'h1);
      summarize();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] rd;
    wb(1'b1, adr, dat, rd);
  endtask

  task automatic rdchk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    wb(1'b0, adr, 32'h0, rd);
    check(name, rd, exp);
  endtask

  function automatic logic [31:0] cfg(input logic [1:0] s, input logic [1:0] i,
                                      input logic [3:0] o);
    return {24'h0, o, i, s};
  endfunction

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    rdchk("cgc_reset", 8'h00, 32'h0);
    rdchk("sc1_reset", 8'h04, 32'h0);
    rdchk("imbc_reset", 8'h08, 32'h1);
    rdchk("status_reset", 8'h0c, 32'h0);
    check("enable_reset", pll_enable_o, 32'h0);
  endtask

  // Reserved source and band are dropped; output prescale 15 saturates.
  task automatic t_regs;
    wr(8'h00, 32'h7afe);
    rdchk("cgc_sat", 8'h00, 32'h1aec);
    check("mul_out", feedback_multiply_factor_o, 32'h1a);
    rdchk("unmapped", 8'h10, 32'h0);
    wb_sel_i <= 4'h1;
    wr(8'h00, 32'h4305);
    rdchk("cgc_lane0", 8'h00, 32'h1a05);
    wb_sel_i <= 4'h2;
    wr(8'h00, 32'h4305);
    rdchk("cgc_lane1", 8'h00, 32'h4305);
    wb_sel_i <= 4'hf;
    for (int b = 0; b < 3; b++)
    begin
      wr(8'h00, 32'(b) << 13);
      check("band_out", vco_band_select_o, 32'(b));
    end
  endtask

  task automatic measure(input int idx, output int per, output int hi);
    logic prev;
    logic cur;
    int edges;
    prev = 1'b1;
    edges = 0;
    per = 0;
    hi = 0;
    for (int n = 0; n < 3000 && edges < 3; n++)
    begin
      @(posedge clk_i);
      #1;
      cur = (idx == 2) ? pll_ref_o : ((idx == 1) ? cpu_clk_o : master_clk_o);
      if (cur === 1'b1 && prev === 1'b0)
        edges++;
      if (edges == 2)
      begin
        per++;
        if (cur === 1'b1)
          hi++;
      end
      prev = cur;
    end
    if (edges < 3)
    begin
      check("clock_wait", 32'h0, 32'h1);
      summarize();
    end
  endtask

  task automatic clk_case(input string name, input logic [31:0] c, input logic halve,
                          input int idx, input int exp_per, input int exp_hi);
    int per;
    int hi;
    wr(8'h00, c);
    wr(8'h04, {31'h0, halve});
    measure(idx, per, hi);
    check(name, 32'(per), 32'(exp_per));
    if (exp_hi >= 0)
      check(name, 32'(hi), 32'(exp_hi));
  endtask

  task automatic t_loop;
    clk_case("loop_div", cfg(2'h3, 2'h0, 4'h2), 1'b0, 1'b0, 12, -1);
    check("enable_loop", pll_enable_o, 32'h1);
    rdchk("status_loop", 8'h0c, 32'h1);
    wr(8'h00, cfg(2'h2, 2'h0, 4'h2));
    check("enable_kept", pll_enable_o, 32'h1);
    wr(8'h00, cfg(2'h0, 2'h0, 4'h0));
    check("enable_off", pll_enable_o, 32'h0);
  endtask

  task automatic flash_acc(input logic seq, input int ws, input int exp,
                           input logic [15:0] pat);
    int n;
    wr(8'h08, 32'(ws));
    @(posedge clk_i);
    flash_rdata_i <= pat;
    acc_req_i <= 1'b1;
    acc_seq_i <= seq;
    @(posedge clk_i);
    acc_req_i <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_i);
      acc_req_i <= (n == 0 && ws > 1);
      #1;
      n++;
    end
    while (acc_done_o !== 1'b1 && n < 10);
    check("flash_cycles", 32'(n), 32'(exp));
    check("flash_data", {16'h0, acc_rdata_o}, {16'h0, pat});
    n = 0;
    repeat (6)
    begin
      @(posedge clk_i);
      #1;
      if (acc_done_o !== 1'b0)
        n++;
    end
    check("flash_refused", 32'(n), 32'h0);
  endtask

  task automatic t_flash;
    for (int w = 0; w < 4; w++)
      flash_acc(1'b0, w, 1 + w, 16'ha5c0 + 16'(w));
    flash_acc(1'b1, 1, 1, 16'h3c5a);
  endtask

  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    clk_case("bypass_pass", cfg(2'h0, 2'h0, 4'h0), 1'b0, 1'b0, 8, 4);
    clk_case("bypass_div", cfg(2'h0, 2'h1, 4'h2), 1'b0, 1'b0, 48, -1);
    clk_case("ref_div", cfg(2'h0, 2'h1, 4'h0), 1'b0, 2, 16, 8);
    clk_case("bypass_slow", cfg(2'h1, 2'h3, 4'he), 1'b0, 1'b0, 480, -1);
    clk_case("cpu_full", cfg(2'h0, 2'h0, 4'h0), 1'b0, 1'b1, 8, -1);
    clk_case("cpu_half", cfg(2'h0, 2'h0, 4'h0), 1'b1, 1'b1, 16, 8);
    rdchk("status_half", 8'h0c, 32'h2);
    t_loop();
    t_flash();
    summarize();
  end
endmodule

// *** logic/mcc_clk_div.sv ***
// Purpose: Divides a sampled clock level by ratio plus one.
// Assumes: clk_i runs well faster than the incoming clock level.
// Notes: A ratio of zero passes the level straight through.
`timescale 1ns/10ps
module mcc_clk_div #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Clock level in and divided level out
  input wire logic clk_lvl_i,
  input wire logic [W-1:0] ratio_i,
  output logic clk_lvl_o
);

  logic prev_q;
  logic prev_d;
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic div_q;
  logic div_d;

  always_comb
  begin
    prev_d = clk_lvl_i;
    cnt_d = cnt_q;
    if (clk_lvl_i && !prev_q)
    begin
      if (cnt_q >= ratio_i)
        cnt_d = '0;
      else
        cnt_d = cnt_q + 1'b1;
    end
    div_d = (cnt_d <= (ratio_i >> 1));
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prev_q <= 1'b0;
      cnt_q <= '0;
      div_q <= 1'b0;
    end
    else
    begin
      prev_q <= prev_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
    end
  end

  assign clk_lvl_o = (ratio_i == '0) ? clk_lvl_i : div_q;

endmodule

// *** logic/mcc_clk_sel.sv ***
// Purpose: Glitch-free choice between two clock levels.
// Assumes: Both levels are sampled in the clk_i domain.
// Notes: The choice only moves while both candidates are low.
`timescale 1ns/10ps
module mcc_clk_sel (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Candidates and choice
  input wire logic a_i,
  input wire logic b_i,
  input wire logic sel_i,
  output logic sel_o,
  output logic clk_lvl_o
);

  logic sel_q;
  logic sel_d;

  // Moving only while both are low means no output edge comes from the switch.
  always_comb
  begin
    sel_d = sel_q;
    if (!a_i && !b_i)
      sel_d = sel_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sel_q <= 1'b0;
    else
      sel_q <= sel_d;
  end

  assign sel_o = sel_q;
  assign clk_lvl_o = sel_q ? b_i : a_i;

endmodule

// *** logic/mcc_pkg.sv ***
// Purpose: Shared constants of the master clock and flash wait control block.
// Assumes: 32-bit classic Wishbone register port, word-aligned registers.
// Notes: Field positions are low bit and width of each control field.
package mcc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] MCC_OFS_CLOCK_GENERATION_CONTROL = 8'h00;
  localparam logic [7:0] MCC_OFS_SYSTEM_CONFIGURATION_ONE = 8'h04;
  localparam logic [7:0] MCC_OFS_INTERNAL_MEMORY_BUS_CONTROL = 8'h08;
  localparam logic [7:0] MCC_OFS_STATUS = 8'h0c;

  // ----------------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------------
  localparam int MCC_SRC_LSB = 0;
  localparam int MCC_SRC_W = 2;
  localparam int MCC_IDIV_LSB = 2;
  localparam int MCC_IDIV_W = 2;
  localparam int MCC_ODIV_LSB = 4;
  localparam int MCC_ODIV_W = 4;
  localparam int MCC_MUL_LSB = 8;
  localparam int MCC_MUL_W = 5;
  localparam int MCC_VCOB_LSB = 13;
  localparam int MCC_VCOB_W = 2;
  localparam int MCC_HALF_BIT = 0;
  localparam int MCC_WS_LSB = 0;
  localparam int MCC_WS_W = 2;

  // ----------------------------------------------------------------------
  // Field limits and codes
  // ----------------------------------------------------------------------
  localparam logic [MCC_ODIV_W-1:0] MCC_ODIV_MAX = 4'he;
  localparam logic [MCC_SRC_W-1:0] MCC_SRC_LOOP = 2'h3;
  localparam logic [MCC_VCOB_W-1:0] MCC_VCOB_RESERVED = 2'h3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [MCC_SRC_W-1:0] MCC_RST_SRC = 2'h0;
  localparam logic [MCC_IDIV_W-1:0] MCC_RST_IDIV = 2'h0;
  localparam logic [MCC_ODIV_W-1:0] MCC_RST_ODIV = 4'h0;
  localparam logic [MCC_MUL_W-1:0] MCC_RST_MUL = 5'h00;
  localparam logic [MCC_VCOB_W-1:0] MCC_RST_VCOB = 2'h0;
  localparam logic MCC_RST_HALF = 1'b0;
  localparam logic [MCC_WS_W-1:0] MCC_RST_WS = 2'h1;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int MCC_CLK_PERIOD_NS = 50;
  localparam int MCC_FLASH_ACCESS_NS = 50;
  // Least cycles that cover one flash access at the bus clock rate.
  localparam int MCC_FLASH_ACCESS_CYC =
    (MCC_FLASH_ACCESS_NS + MCC_CLK_PERIOD_NS - 1) / MCC_CLK_PERIOD_NS;

endpackage

// *** logic/mcc_top.sv ***
// Purpose: Master, CPU and system clock generation with flash wait control.
// Assumes: clk_i samples the oscillator and VCO levels at well above their rate.
// Notes: Registers are reached over classic Wishbone with one registered ack in the cycle after the request.
// Notes on behaviour
// RL1: Bypass divides oscillator by input prescale plus one times output prescale plus one.
// RL2: Source code 11 enables loop; output is oscillator times multiply over both prescales.
// RL3: Input prescale reaches 3, output prescale 14; both maximum give slowest bypass.
// RL4: Both prescales zero in bypass pass the oscillator straight through.
// RL5: CPU clock equals master clock or master halved, chosen by one bit.
// RL6: System clock runs at exactly the CPU clock frequency.
// RL7: In loop mode the VCO output is divided by output prescale plus one.
// RL8: VCO band codes 00, 01, 10 select bands; code 11 is reserved.
// RL9: Each non-sequential flash access completes in one plus the programmed waitstate cycles.
// RL10: Software picks waitstates covering the 50 ns flash access time.
// RL11: Waitstate code 00 means none up to 20 MHz, 01 one up to 40 MHz.
// RL12: Waitstates apply only to non-sequential accesses; sequential ones are prefetched.
// RL13: Clock switching produces no runt pulses or glitches on CPU and system clocks.
// RL14: Reserved source codes leave the current master clock source unchanged.
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
module mcc_top
  import mcc_pkg::*;
#(
  parameter int MUL_W = mcc_pkg::MCC_MUL_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Oscillator and analog loop
  input wire logic oscillator_input_i,
  input wire logic vco_clk_i,
  output logic pll_ref_o,
  output logic pll_enable_o,
  output logic [MUL_W-1:0] feedback_multiply_factor_o,
  output logic [mcc_pkg::MCC_VCOB_W-1:0] vco_band_select_o,
  // Generated clocks
  output logic master_clk_o,
  output logic cpu_clk_o,
  output logic sys_clk_o,
  // Program memory interface
  input wire logic acc_req_i,
  input wire logic acc_seq_i,
  input wire logic [15:0] flash_rdata_i,
  output logic acc_busy_o,
  output logic acc_done_o,
  output logic [15:0] acc_rdata_o
);

  import mcc_pkg::*;

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic [MCC_SRC_W-1:0] src_q;
  logic [MCC_SRC_W-1:0] src_d;
  logic [MCC_IDIV_W-1:0] idiv_q;
  logic [MCC_IDIV_W-1:0] idiv_d;
  logic [MCC_ODIV_W-1:0] odiv_q;
  logic [MCC_ODIV_W-1:0] odiv_d;
  logic [MUL_W-1:0] mul_q;
  logic [MUL_W-1:0] mul_d;
  logic [MCC_VCOB_W-1:0] vcob_q;
  logic [MCC_VCOB_W-1:0] vcob_d;
  logic half_q;
  logic half_d;
  logic [MCC_WS_W-1:0] ws_q;
  logic [MCC_WS_W-1:0] ws_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;

  logic wr_lo;
  logic wr_hi;
  logic [MCC_SRC_W-1:0] wsrc;
  logic [MCC_ODIV_W-1:0] wodiv;
  logic [MCC_VCOB_W-1:0] wvcob;

  // Status seen by software.
  logic loop_active;
  logic half_active;

  assign wr_lo = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
  assign wr_hi = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[1];
  assign wsrc = wb_dat_i[MCC_SRC_LSB +: MCC_SRC_W];
  assign wodiv = wb_dat_i[MCC_ODIV_LSB +: MCC_ODIV_W];
  assign wvcob = wb_dat_i[MCC_VCOB_LSB +: MCC_VCOB_W];

  always_comb
  begin
    src_d = src_q;
    idiv_d = idiv_q;
    odiv_d = odiv_q;
    mul_d = mul_q;
    vcob_d = vcob_q;
    half_d = half_q;
    ws_d = ws_q;
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d = 32'h0000_0000;
    case (wb_adr_i)
      MCC_OFS_CLOCK_GENERATION_CONTROL:
      begin
        if (wr_lo)
        begin
          if (!wsrc[1] || wsrc == MCC_SRC_LOOP) // RL14
            src_d = wsrc;
          idiv_d = wb_dat_i[MCC_IDIV_LSB +: MCC_IDIV_W]; // RL3
          odiv_d = (wodiv > MCC_ODIV_MAX) ? MCC_ODIV_MAX : wodiv; // RL3
        end
        if (wr_hi)
        begin
          mul_d = wb_dat_i[MCC_MUL_LSB +: MUL_W];
          if (wvcob != MCC_VCOB_RESERVED) // RL8
            vcob_d = wvcob;
        end
        rdat_d[MCC_SRC_LSB +: MCC_SRC_W] = src_q;
        rdat_d[MCC_IDIV_LSB +: MCC_IDIV_W] = idiv_q;
        rdat_d[MCC_ODIV_LSB +: MCC_ODIV_W] = odiv_q;
        rdat_d[MCC_MUL_LSB +: MUL_W] = mul_q;
        rdat_d[MCC_VCOB_LSB +: MCC_VCOB_W] = vcob_q;
      end
      MCC_OFS_SYSTEM_CONFIGURATION_ONE:
      begin
        if (wr_lo)
          half_d = wb_dat_i[MCC_HALF_BIT]; // RL5
        rdat_d[MCC_HALF_BIT] = half_q;
      end
      MCC_OFS_INTERNAL_MEMORY_BUS_CONTROL:
      begin
        if (wr_lo)
          ws_d = wb_dat_i[MCC_WS_LSB +: MCC_WS_W]; // RL11
        rdat_d[MCC_WS_LSB +: MCC_WS_W] = ws_q;
      end
      MCC_OFS_STATUS:
      begin
        rdat_d[0] = loop_active;
        rdat_d[1] = half_active;
        rdat_d[2] = acc_busy_o;
      end
      default:
      begin
        rdat_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      src_q <= MCC_RST_SRC;
      idiv_q <= MCC_RST_IDIV;
      odiv_q <= MCC_RST_ODIV;
      mul_q <= MUL_W'(MCC_RST_MUL);
      vcob_q <= MCC_RST_VCOB;
      half_q <= MCC_RST_HALF;
      ws_q <= MCC_RST_WS;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      src_q <= src_d;
      idiv_q <= idiv_d;
      odiv_q <= odiv_d;
      mul_q <= mul_d;
      vcob_q <= vcob_d;
      half_q <= half_d;
      ws_q <= ws_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] osc_sync_q;
  logic [1:0] vco_sync_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      osc_sync_q <= 2'h0;
      vco_sync_q <= 2'h0;
    end
    else
    begin
      osc_sync_q <= {osc_sync_q[0], oscillator_input_i};
      vco_sync_q <= {vco_sync_q[0], vco_clk_i};
    end
  end

  // ----------------------------------------------------------------------
  // Master clock path
  // ----------------------------------------------------------------------
  logic ref_lvl;
  logic odiv_src_lvl;
  logic master_lvl;
  logic want_loop;

  // The input prescaler feeds both the bypass chain and the loop reference.
  mcc_clk_div #(
    .W(MCC_IDIV_W)
  ) u_idiv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clk_lvl_i(osc_sync_q[1]),
    .ratio_i(idiv_q),
    .clk_lvl_o(ref_lvl)
  ); // RL1

  assign want_loop = (src_q == MCC_SRC_LOOP); // RL2

  mcc_clk_sel u_src_sel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .a_i(ref_lvl),
    .b_i(vco_sync_q[1]),
    .sel_i(want_loop),
    .sel_o(loop_active),
    .clk_lvl_o(odiv_src_lvl)
  ); // RL13

  // One output prescaler serves bypass and loop; zero ratios pass through.
  mcc_clk_div #(
    .W(MCC_ODIV_W)
  ) u_odiv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clk_lvl_i(odiv_src_lvl),
    .ratio_i(odiv_q),
    .clk_lvl_o(master_lvl)
  ); // RL1 RL4 RL7

  assign pll_enable_o = want_loop; // RL2
  assign pll_ref_o = ref_lvl;
  assign feedback_multiply_factor_o = mul_q; // RL2
  assign vco_band_select_o = vcob_q; // RL8
  assign master_clk_o = master_lvl;

  // ----------------------------------------------------------------------
  // CPU and system clocks
  // ----------------------------------------------------------------------
  logic mprev_q;
  logic mprev_d;
  logic halfclk_q;
  logic halfclk_d;
  logic cpu_lvl;

  always_comb
  begin
    mprev_d = master_lvl;
    halfclk_d = halfclk_q;
    if (master_lvl && !mprev_q)
      halfclk_d = !halfclk_q; // RL5
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mprev_q <= 1'b0;
      halfclk_q <= 1'b0;
    end
    else
    begin
      mprev_q <= mprev_d;
      halfclk_q <= halfclk_d;
    end
  end

  mcc_clk_sel u_cpu_sel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .a_i(master_lvl),
    .b_i(halfclk_q),
    .sel_i(half_q),
    .sel_o(half_active),
    .clk_lvl_o(cpu_lvl)
  ); // RL5 RL13

  assign cpu_clk_o = cpu_lvl;
  assign sys_clk_o = cpu_lvl; // RL6

  // ----------------------------------------------------------------------
  // Flash access timing
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {
    MCC_ACC_IDLE = 1'b0,
    MCC_ACC_WAIT = 1'b1
  } mcc_acc_state_t;

  mcc_acc_state_t acc_q;
  mcc_acc_state_t acc_d;
  logic [MCC_WS_W-1:0] wcnt_q;
  logic [MCC_WS_W-1:0] wcnt_d;
  logic done_q;
  logic done_d;
  logic [15:0] data_q;
  logic [15:0] data_d;

  always_comb
  begin
    acc_d = acc_q;
    wcnt_d = wcnt_q;
    done_d = 1'b0;
    data_d = data_q;
    case (acc_q)
      MCC_ACC_IDLE:
      begin
        if (acc_req_i)
        begin
          acc_d = MCC_ACC_WAIT;
          wcnt_d = acc_seq_i ? '0 : ws_q; // RL12
        end
      end
      MCC_ACC_WAIT:
      begin
        if (wcnt_q == '0)
        begin
          acc_d = MCC_ACC_IDLE;
          done_d = 1'b1; // RL9
          data_d = flash_rdata_i;
        end
        else
          wcnt_d = wcnt_q - 1'b1; // RL9
      end
      default:
      begin
        acc_d = MCC_ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_q <= MCC_ACC_IDLE;
      wcnt_q <= '0;
      done_q <= 1'b0;
      data_q <= 16'h0000;
    end
    else
    begin
      acc_q <= acc_d;
      wcnt_q <= wcnt_d;
      done_q <= done_d;
      data_q <= data_d;
    end
  end

  assign acc_busy_o = (acc_q == MCC_ACC_WAIT);
  assign acc_done_o = done_q;
  assign acc_rdata_o = data_q;

endmodule
